/* File: logic/rrex_pkg.sv */
// Constants and carrier types for the return and rotate execution block.
// Assumes a core that fetches, decodes and hands over one instruction
// at a time, and that owns the file registers and the return stack.
package rrex_pkg;
  localparam int          PC_W         = 15;
  localparam int          FADDR_W      = 7;
  localparam int          DATA_W       = 8;
  localparam int          INT_EN_BIT   = 7;
  localparam int          RET_CYCLES   = 2;
  localparam logic [7:0]  INT_CTRL_RST = 8'h00;
  localparam logic [7:0]  W_RST        = 8'h00;
  localparam logic [14:0] PC_RST       = 15'h0000;

  typedef enum logic [2:0] {
    RRX_OP_RETFI = 3'h0,
    RRX_OP_RET   = 3'h1,
    RRX_OP_RETL  = 3'h2,
    RRX_OP_RLC   = 3'h3,
    RRX_OP_RRC   = 3'h4
  } rrx_op_t;

  typedef struct packed {
    rrx_op_t             op;
    logic [7:0]          literal;
    logic [6:0]          faddr;
    logic                dest_file;
  } rrx_instr_t;

  typedef struct packed {
    logic                we;
    logic [6:0]          addr;
    logic [7:0]          data;
  } rrx_fwrite_t;

  typedef enum logic [1:0] {
    RRX_IDLE = 2'b01,
    RRX_RET2 = 2'b10
  } rrx_state_t;
endpackage

/* File: logic/rrex_exec.sv */
// Execution of returns and rotates through carry.
// Assumes the core presents one instruction with start_i, supplies the
// addressed file value combinationally and the stack top, and holds the
// next instruction while busy_o is high.
// Stack depth, overflow and interrupt entry belong to the core; this
// block only pops and reloads the program counter.
`timescale 1ns/1ps
module rrex_exec
  import rrex_pkg::*;
#(
  // Program counter width; stack entries match it
  parameter int PC_WIDTH = PC_W
)
(
  // Clock and reset
  input  wire logic                mclk_i,
  input  wire logic                reset_i,
  // Instruction hand-over
  input  wire logic                start_i,
  input  wire rrx_instr_t          instr_i,
  output logic                     busy_o,
  output logic                     done_o,
  // Operands from the core
  input  wire logic [7:0]          fdata_i,
  input  wire logic [PC_WIDTH-1:0] stack_top_i,
  // Architectural state
  output logic [PC_WIDTH-1:0]      pc_o,
  output logic [7:0]               wreg_o,
  output logic [7:0]               int_ctrl_o,
  output logic                     carry_o,
  output logic                     pop_o,
  output rrx_fwrite_t              fwrite_o
);

  // Sequencer state and the return carried into its second cycle
  rrx_state_t          state_q;
  rrx_op_t             op_q;
  logic [7:0]          lit_q;

  // Decoded view of the offered instruction
  logic                is_ret;
  logic                is_rlc;
  logic                in_idle;
  logic                in_ret2;
  logic                take_ret;
  logic                take_rot;
  logic                fin_ret_fi;
  logic                fin_ret_lit;
  logic [8:0]          rot_res;
  logic [PC_WIDTH-1:0] pc_rst;

  // Return opcodes share the two-cycle path
  function automatic logic ret_op(input rrx_op_t o);
    ret_op = (o == RRX_OP_RETFI) ||
             (o == RRX_OP_RET)   ||
             (o == RRX_OP_RETL);
  endfunction

  // Rotate through carry; result byte in [7:0], new carry in [8]
  function automatic logic [8:0] rot9(input logic left, input logic c,
                                      input logic [7:0] v);
    if (left)
      rot9 = {v[7], v[6:0], c};
    else
      rot9 = {v[0], c, v[7:1]};
  endfunction

  assign is_ret      = ret_op(instr_i.op);
  assign is_rlc      = instr_i.op == RRX_OP_RLC;
  assign in_idle     = state_q == RRX_IDLE;
  assign in_ret2     = state_q == RRX_RET2;
  // Starts in the second return cycle are dropped; the core holds them off
  assign take_ret    = in_idle &&
                       start_i &&
                       is_ret;
  assign take_rot    = in_idle &&
                       start_i &&
                       !is_ret;
  assign fin_ret_fi  = in_ret2 &&
                       (op_q == RRX_OP_RETFI);
  assign fin_ret_lit = in_ret2 &&
                       (op_q == RRX_OP_RETL);
  // Unknown codes fall through to the right rotate
  assign rot_res     = rot9(is_rlc, carry_o, fdata_i);
  assign pc_rst      = PC_WIDTH'(PC_RST);

  // Sequencer: returns hold a second cycle, rotates finish at once
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state_q <= RRX_IDLE;
    end else begin
      unique case (state_q)
        RRX_IDLE: begin
          if (take_ret) begin
            state_q <= RRX_RET2;
          end else begin
            state_q <= RRX_IDLE;
          end
        end
        RRX_RET2: begin
          state_q <= RRX_IDLE;
        end
        default: begin
          state_q <= RRX_IDLE;
        end
      endcase
    end
  end

  // Return opcode kept for the second cycle
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      op_q <= RRX_OP_RET;
    end else if (take_ret) begin
      op_q <= instr_i.op;
    end
  end

  // Literal kept so the core may move on to the next fetch
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      lit_q <= 8'h00;
    end else if (take_ret) begin
      lit_q <= instr_i.literal;
    end
  end

  // Busy covers exactly the second return cycle
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= take_ret;
    end
  end

  // Done: one cycle after a rotate, or at the end of a return
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      done_o <= 1'b0;
    end else begin
      done_o <= in_ret2 ||
                take_rot;
    end
  end

  // Program counter loads the stack top in the second return cycle
  // The stack top is taken as it stands then; the core must have it settled
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pc_o <= pc_rst;
    end else if (in_ret2) begin
      pc_o <= stack_top_i;
    end
  end

  // Pop strobe lands on the same edge as the program counter load
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pop_o <= 1'b0;
    end else begin
      pop_o <= in_ret2;
    end
  end

  // Only the interrupt return touches the interrupt control register
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      int_ctrl_o <= INT_CTRL_RST;
    end else if (fin_ret_fi) begin
      int_ctrl_o[INT_EN_BIT] <= 1'b1;
    end
  end

  // Working register: literal on the RETL return, rotate result when d is 0
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      wreg_o <= W_RST;
    end else if (fin_ret_lit) begin
      wreg_o <= lit_q;
    end else if (take_rot &&
                 !instr_i.dest_file) begin
      wreg_o <= rot_res[7:0];
    end
  end

  // Carry is the only flag here; returns never write it
  // Reset clears it so the first rotate shifts in a known value
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      carry_o <= 1'b0;
    end else if (take_rot) begin
      carry_o <= rot_res[8];
    end
  end

  // File write strobe when d is 1; one cycle per rotate
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      fwrite_o.we <= 1'b0;
    end else begin
      fwrite_o.we <= take_rot &&
                     instr_i.dest_file;
    end
  end

  // Address and data follow every cycle; only the strobe qualifies them
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      fwrite_o.addr <= 7'h00;
      fwrite_o.data <= 8'h00;
    end else begin
      fwrite_o.addr <= instr_i.faddr;
      fwrite_o.data <= rot_res[7:0];
    end
  end

endmodule // rrex_exec

/* File: tb/rrex_exec_monitor.sv */
// Port checker for rrex_exec.
// Assumes rrex_pkg is compiled first; bound below.
`timescale 1ns/1ps
module rrex_exec_monitor
  import rrex_pkg::*;
(
  input wire logic        mclk_i, reset_i, start_i, busy_o, done_o,
  input wire logic        carry_o, pop_o,
  input wire rrx_instr_t  instr_i,
  input wire logic [7:0]  fdata_i, wreg_o, int_ctrl_o,
  input wire logic [14:0] stack_top_i, pc_o,
  input wire rrx_fwrite_t fwrite_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  logic    tk;
  rrx_op_t op;
  assign tk = start_i && !busy_o;
  assign op = instr_i.op;
  // Second cycle ends in the pop
  sequence s_ret_end;
    busy_o ##1 (pop_o && done_o && !busy_o);
  endsequence
  AST_RET_PC: assert property (
    tk && op inside {RRX_OP_RETFI, RRX_OP_RET, RRX_OP_RETL}
    |=> s_ret_end ##0 pc_o == $past(stack_top_i)) else $error("ret");
  AST_RET_EN: assert property (
    tk && op == RRX_OP_RETFI |=> ##1 int_ctrl_o[INT_EN_BIT]) else $error("en");
  AST_RET_KEEP: assert property (
    tk && op == RRX_OP_RET |=> ##1 $stable(wreg_o) && $stable(carry_o))
    else $error("keep");
  AST_RETL_W: assert property (
    tk && op == RRX_OP_RETL |=> ##1 wreg_o == $past(instr_i.literal, 2))
    else $error("lit");
  AST_RLC_C: assert property (
    tk && op == RRX_OP_RLC |=> done_o && carry_o == $past(fdata_i[7]))
    else $error("lc");
  AST_RLC_W: assert property (
    tk && op == RRX_OP_RLC && !instr_i.dest_file |=> !fwrite_o.we &&
    wreg_o == {$past(fdata_i[6:0]), $past(carry_o)}) else $error("lw");
  AST_RRC_C: assert property (
    tk && op == RRX_OP_RRC |=> done_o && carry_o == $past(fdata_i[0]))
    else $error("rc");
  AST_RRC_F: assert property (
    tk && op == RRX_OP_RRC && instr_i.dest_file |=> fwrite_o.we &&
    fwrite_o.data == {$past(carry_o), $past(fdata_i[7:1])}) else $error("rf");
endmodule // rrex_exec_monitor
bind rrex_exec rrex_exec_monitor rrex_exec_monitor_inst (.*);

/* File: tb/tb.sv */
// Bench for rrex_exec: rotates and returns judged at the ports.
// Assumes rrex_pkg, the design and its monitor are compiled first.
`timescale 1ns/1ps
module tb;
  import rrex_pkg::*;
  logic        mclk_i = 0, reset_i = 1, start_i = 0;
  logic        busy_o, done_o, carry_o, pop_o;
  rrx_instr_t  instr_i = '0;
  rrx_fwrite_t fwrite_o;
  logic [7:0]  fdata_i = 8'h00, wreg_o, int_ctrl_o;
  logic [14:0] stack_top_i = 15'h0000, pc_o;
  int          n_mismatch = 0, n_compared = 0;
  always #10 mclk_i = ~mclk_i;
  rrex_exec rrex_exec_inst (
    .mclk_i      (mclk_i),
    .reset_i     (reset_i),
    .start_i     (start_i),
    .instr_i     (instr_i),
    .busy_o      (busy_o),
    .done_o      (done_o),
    .fdata_i     (fdata_i),
    .stack_top_i (stack_top_i),
    .pc_o        (pc_o),
    .wreg_o      (wreg_o),
    .int_ctrl_o  (int_ctrl_o),
    .carry_o     (carry_o),
    .pop_o       (pop_o),
    .fwrite_o    (fwrite_o)
  );
  task automatic chk(input logic [15:0] s, e);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %0t %h %h", $time, s, e);
    end
  endtask
  // Held one cycle only; the taking edge drops it
  task automatic go(input rrx_op_t o, input logic [7:0] k, f,
                    input logic d, input logic [14:0] t);
    @(posedge mclk_i);
    start_i <= 1'b1;
    instr_i <= '{o, k, 7'h2a, d};
    fdata_i <= f;
    stack_top_i <= t;
    @(posedge mclk_i);
    start_i <= 1'b0;
    #1;
  endtask
  task automatic t_rot(input rrx_op_t o, input logic [7:0] f, r,
                       input logic d, c);
    go(o, 8'h00, f, d, 15'h0000);
    chk(carry_o, c);
    chk(d ? fwrite_o.data : wreg_o, r);
    chk({fwrite_o.we, done_o}, {d, 1'b1});
    chk(fwrite_o.addr, 7'h2a);
  endtask
  task automatic t_ret(input rrx_op_t o, input logic [7:0] k,
                       input logic [14:0] t);
    logic [7:0] w;
    w = wreg_o;
    go(o, k, 8'h00, 1'b0, t);
    chk(busy_o, 1'b1);
    @(posedge mclk_i);
    #1;
    chk({pc_o, pop_o}, {t, 1'b1});
    chk({busy_o,done_o,int_ctrl_o}, {2'b01,o == RRX_OP_RETFI,7'h0});
    chk(wreg_o, o == RRX_OP_RETL ? k : w);
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge mclk_i);
    reset_i <= 1'b0;
    #1;
    chk({pc_o[7:0], wreg_o}, 16'h0000);
    t_rot(RRX_OP_RLC, 8'he6, 8'hcc, 1'b0, 1'b1);
    t_rot(RRX_OP_RRC, 8'h01, 8'h80, 1'b1, 1'b1);
    t_rot(RRX_OP_RRC, 8'h02, 8'h81, 1'b0, 1'b0);
    t_rot(RRX_OP_RLC, 8'h80, 8'h00, 1'b1, 1'b1);
    t_ret(RRX_OP_RET, 8'h5a, 15'h1234);
    t_ret(RRX_OP_RETL, 8'hff, 15'h7fff);
    t_ret(RRX_OP_RETFI, 8'h00, 15'h0001);
    end_of_test();
  end
endmodule // tb
